// File: design/pzg_port0.sv
// Port 0 nibble I/O with the port data and mode register set, Wishbone slave.
// Assumes synchronous pins and a stop-recovery pulse from the power controller.
`timescale 1ns/1ps

module pzg_port0 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [pzg_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic stop_recover_i,
  input wire logic tx_enable_i,
  input wire logic tx_data_i,
  input wire logic [pzg_pkg::DATA_W-1:0] pin_in_i,
  output logic [pzg_pkg::DATA_W-1:0] pin_out_o,
  output logic [pzg_pkg::DATA_W-1:0] pin_oe_o
);
  import pzg_pkg::*;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] port_zero_data;
    logic [7:0] port_one_data;
    logic [7:0] port_two_data;
    logic [7:0] port_three_data;
    logic [7:0] port_four_data;
    logic [7:0] port_driver_config;
    logic [7:0] port_four_direction;
    logic [7:0] port_two_direction;
    logic [7:0] port_three_function;
    logic [7:0] port_zero_one_direction;
  } pzg_state_s;

  pzg_state_s state;
  pzg_state_s next_state;

  logic [7:0] reg_idx;
  logic bank_f;
  logic req;
  logic wr_now;
  logic [7:0] pin_view;
  logic [7:0] read_mux;
  logic [7:0] nib_out;
  logic [7:0] drive_data;

  assign reg_idx = adr_i[9:2];
  assign bank_f = adr_i[BANK_F_BIT];
  assign req = cyc_i & stb_i;
  // Writes land on the edge the master sees ack, so a write is never applied twice
  assign wr_now = req & we_i & state.ack & sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  generate
    for (genvar b = 0; b < DATA_W; b++) begin : g_bit
      localparam int DIR_BIT = (b < 4) ? P01_LOW_IN_BIT : P01_HIGH_IN_BIT;
      // A clear mode bit makes the whole nibble an output
      assign nib_out[b] = ~state.port_zero_one_direction[DIR_BIT];
      // Input nibbles read the pin, output nibbles read back the latch
      assign pin_view[b] = nib_out[b] ? state.port_zero_data[b] : pin_in_i[b];
    end
  endgenerate

  always_comb begin
    drive_data = state.port_zero_data;
    // Transmit needs the high nibble set as output to reach the pin
    if (tx_enable_i) begin
      drive_data[TX_PIN_BIT] = tx_data_i;
    end
  end

  always_comb begin
    if (state.port_driver_config[DRV_PUSH_PULL_BIT]) begin
      pin_out_o = drive_data;
      pin_oe_o = nib_out;
    end else begin
      // Open-drain: only pull low, release the line for a one
      pin_out_o = 8'h00;
      pin_oe_o = nib_out & ~drive_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb begin
    read_mux = 8'h00;
    if (reg_idx == IDX_PORT_TWO_DIRECTION) begin
      read_mux = state.port_two_direction;
    end else if (reg_idx == IDX_PORT_THREE_FUNCTION) begin
      read_mux = state.port_three_function;
    end else if (reg_idx == IDX_PORT_ZERO_ONE_DIRECTION) begin
      read_mux = state.port_zero_one_direction;
    end else if (bank_f) begin
      if (reg_idx == IDX_PORT_DRIVER_CONFIG) begin
        read_mux = state.port_driver_config;
      end else if (reg_idx == IDX_PORT_FOUR_DIRECTION) begin
        read_mux = state.port_four_direction;
      end
    end else begin
      unique case (reg_idx)
        IDX_PORT_ZERO_DATA: read_mux = pin_view;
        IDX_PORT_ONE_DATA: read_mux = state.port_one_data;
        IDX_PORT_TWO_DATA: read_mux = state.port_two_data;
        IDX_PORT_THREE_DATA: read_mux = state.port_three_data;
        IDX_PORT_FOUR_DATA: read_mux = state.port_four_data;
        default: read_mux = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;
    next_state.ack = req & ~state.ack;
    if (req & ~state.ack) begin
      next_state.rdata = read_mux;
    end
    if (wr_now) begin
      if (reg_idx == IDX_PORT_TWO_DIRECTION) begin
        next_state.port_two_direction = dat_i[7:0];
      end else if (reg_idx == IDX_PORT_THREE_FUNCTION) begin
        next_state.port_three_function = dat_i[7:0];
      end else if (reg_idx == IDX_PORT_ZERO_ONE_DIRECTION) begin
        next_state.port_zero_one_direction = dat_i[7:0];
      end else if (bank_f) begin
        if (reg_idx == IDX_PORT_DRIVER_CONFIG) begin
          next_state.port_driver_config = dat_i[7:0];
        end else if (reg_idx == IDX_PORT_FOUR_DIRECTION) begin
          next_state.port_four_direction = dat_i[7:0];
        end
      end else begin
        unique case (reg_idx)
          IDX_PORT_ZERO_DATA: next_state.port_zero_data = dat_i[7:0];
          IDX_PORT_ONE_DATA: next_state.port_one_data = dat_i[7:0];
          IDX_PORT_TWO_DATA: next_state.port_two_data = dat_i[7:0];
          IDX_PORT_THREE_DATA: next_state.port_three_data = dat_i[7:0];
          IDX_PORT_FOUR_DATA: next_state.port_four_data = dat_i[7:0];
          default: next_state.port_four_data = state.port_four_data;
        endcase
      end
    end
    // Recovery wins over a write in the same cycle so the port never wakes driving
    if (stop_recover_i) begin
      next_state.port_zero_one_direction[P01_LOW_IN_BIT] = 1'b1;
      next_state.port_zero_one_direction[P01_HIGH_IN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.ack <= 1'b0;
      state.rdata <= RST_DATA;
      state.port_zero_data <= RST_DATA;
      state.port_one_data <= RST_DATA;
      state.port_two_data <= RST_DATA;
      state.port_three_data <= RST_DATA;
      state.port_four_data <= RST_DATA;
      state.port_driver_config <= RST_PORT_DRIVER_CONFIG;
      state.port_four_direction <= RST_PORT_FOUR_DIRECTION;
      state.port_two_direction <= RST_PORT_TWO_DIRECTION;
      state.port_three_function <= RST_PORT_THREE_FUNCTION;
      state.port_zero_one_direction <= RST_PORT_ZERO_ONE_DIRECTION;
    end else begin
      state <= next_state;
    end
  end

  assign ack_o = state.ack;
  assign dat_o = {24'h00_0000, state.rdata};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Pin checks read registered state and live inputs only, so they hold in any cycle

  chk_low_nibble_in: assert property (@(posedge clk_i) disable iff (rst_i)
    state.port_zero_one_direction[P01_LOW_IN_BIT] |-> (pin_oe_o[3:0] == 4'h0))
    else $error("low nibble driven while set as input");

  chk_high_nibble_in: assert property (@(posedge clk_i) disable iff (rst_i)
    state.port_zero_one_direction[P01_HIGH_IN_BIT] |-> (pin_oe_o[7:4] == 4'h0))
    else $error("high nibble driven while set as input");

  chk_nibble_pairs: assert property (@(posedge clk_i) disable iff (rst_i)
    state.port_driver_config[DRV_PUSH_PULL_BIT]
      |-> (pin_oe_o[3:0] == {4{pin_oe_o[0]}}) && (pin_oe_o[7:4] == {4{pin_oe_o[4]}}))
    else $error("lines of one nibble disagree on direction");

  chk_open_drain_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !state.port_driver_config[DRV_PUSH_PULL_BIT]
      |-> (pin_out_o == 8'h00) && ((pin_oe_o & drive_data) == 8'h00))
    else $error("open-drain output drove a high level");

  chk_open_drain_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    (!state.port_driver_config[DRV_PUSH_PULL_BIT]
      && !state.port_zero_one_direction[P01_LOW_IN_BIT])
      |-> (pin_oe_o[3:0] == ~state.port_zero_data[3:0]))
    else $error("open-drain low nibble did not pull its zeros");

  chk_push_pull_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.port_driver_config[DRV_PUSH_PULL_BIT] && !tx_enable_i)
      |-> (pin_out_o == state.port_zero_data))
    else $error("push/pull pins do not show the latch");

  chk_output_nibble_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.port_driver_config[DRV_PUSH_PULL_BIT]
      && !state.port_zero_one_direction[P01_LOW_IN_BIT]) |-> (pin_oe_o[3:0] == 4'hf))
    else $error("output nibble not driven");

  chk_mode_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_now && reg_idx == IDX_PORT_ZERO_ONE_DIRECTION && !stop_recover_i)
      |=> (state.port_zero_one_direction == $past(dat_i[7:0])))
    else $error("mode register write did not take effect");

  chk_mode_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wr_now && !stop_recover_i) |=> $stable(state.port_zero_one_direction))
    else $error("mode register changed without a write");

  chk_stop_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_recover_i |=> (nib_out == 8'h00) && (pin_oe_o == 8'h00))
    else $error("port 0 still driving after stop recovery");

  chk_reset_mode_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> state.port_zero_one_direction[P01_HIGH_IN_BIT]
      && state.port_zero_one_direction[P01_LOW_IN_BIT] && (pin_oe_o == 8'h00))
    else $error("port 0/1 mode reset value wrong");

  chk_reset_p2_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (state.port_two_direction == RST_PORT_TWO_DIRECTION))
    else $error("port 2 mode reset value wrong");

  chk_reset_p3_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (state.port_three_function[FUNC_CLEAR_W-1:0] == 3'b000))
    else $error("port 3 mode low bits not cleared");

  chk_reset_bus_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> !ack_o && (dat_o == 32'h0000_0000))
    else $error("bus not idle after reset");

  chk_tx_override: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_enable_i && !state.port_zero_one_direction[P01_HIGH_IN_BIT]
      && state.port_driver_config[DRV_PUSH_PULL_BIT])
      |-> (pin_out_o[TX_PIN_BIT] == tx_data_i) && pin_oe_o[TX_PIN_BIT])
    else $error("transmit data did not reach pin 7");

  chk_read_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(ack_o) && $past(!we_i && !bank_f && reg_idx == IDX_PORT_ZERO_DATA)
      && $past(state.port_zero_one_direction[P01_LOW_IN_BIT]))
      |-> (dat_o[3:0] == $past(pin_in_i[3:0])))
    else $error("input nibble read did not return pin levels");

  chk_read_pins_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(ack_o) && $past(!we_i && !bank_f && reg_idx == IDX_PORT_ZERO_DATA)
      && $past(state.port_zero_one_direction[P01_HIGH_IN_BIT]))
      |-> (dat_o[7:4] == $past(pin_in_i[7:4])))
    else $error("high input nibble read did not return pin levels");

  chk_read_latch_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(ack_o) && $past(!we_i && !bank_f && reg_idx == IDX_PORT_ZERO_DATA)
      && $past(!state.port_zero_one_direction[P01_LOW_IN_BIT]))
      |-> (dat_o[3:0] == $past(state.port_zero_data[3:0])))
    else $error("output nibble read did not return the latch");

  chk_read_latch_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(ack_o) && $past(!we_i && !bank_f && reg_idx == IDX_PORT_ZERO_DATA)
      && $past(!state.port_zero_one_direction[P01_HIGH_IN_BIT]))
      |-> (dat_o[7:4] == $past(state.port_zero_data[7:4])))
    else $error("high output nibble read did not return the latch");

  chk_data_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_now && !bank_f && reg_idx == IDX_PORT_ZERO_DATA)
      |=> (state.port_zero_data == $past(dat_i[7:0])))
    else $error("port 0 data write did not take effect");

  chk_config_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_now && bank_f && reg_idx == IDX_PORT_DRIVER_CONFIG)
      |=> (state.port_driver_config == $past(dat_i[7:0])))
    else $error("driver configuration write did not take effect");

  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_o) |=> ack_o)
    else $error("request not answered in the next cycle");

  chk_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> $past(req))
    else $error("ack given without a request");

  chk_rdata_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without a new request");

endmodule : pzg_port0

// File: include/pzg_pkg.sv
// Shared constants for the port 0 nibble I/O block and its register set.
// Assumes a Wishbone slave that sees byte addresses; bit 10 picks the F bank.
package pzg_pkg;

  localparam int DATA_W = 8;
  localparam int ADR_W = 11;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_ZERO_DATA = 8'h00;
  localparam logic [7:0] IDX_PORT_ONE_DATA = 8'h01;
  localparam logic [7:0] IDX_PORT_TWO_DATA = 8'h02;
  localparam logic [7:0] IDX_PORT_THREE_DATA = 8'h03;
  localparam logic [7:0] IDX_PORT_FOUR_DATA = 8'h08;
  localparam logic [7:0] IDX_PORT_DRIVER_CONFIG = 8'h00;
  localparam logic [7:0] IDX_PORT_FOUR_DIRECTION = 8'h09;
  localparam logic [7:0] IDX_PORT_TWO_DIRECTION = 8'hf6;
  localparam logic [7:0] IDX_PORT_THREE_FUNCTION = 8'hf7;
  localparam logic [7:0] IDX_PORT_ZERO_ONE_DIRECTION = 8'hf8;

  // Address bit that selects the F bank (set) or banks 0-3 (clear)
  localparam int BANK_F_BIT = 10;

  // Field positions
  localparam int P01_LOW_IN_BIT = 0;
  localparam int P01_HIGH_IN_BIT = 6;
  localparam int DRV_PUSH_PULL_BIT = 2;
  localparam int FUNC_CLEAR_W = 3;
  localparam int TX_PIN_BIT = 7;

  // Reset values; undefined bits of the port 0/1 mode register come up as zero
  localparam logic [7:0] RST_PORT_ZERO_ONE_DIRECTION = 8'h41;
  localparam logic [7:0] RST_PORT_TWO_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT_THREE_FUNCTION = 8'h00;
  localparam logic [7:0] RST_PORT_FOUR_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT_DRIVER_CONFIG = 8'h0e;
  localparam logic [7:0] RST_DATA = 8'h00;

endpackage : pzg_pkg

// File: verification/pzg_pin_board.sv
// Board model for the port 0 pins: resolves each line from the block's drivers.
// Assumes no pull-ups are fitted; undriven lines follow the board's own sources.
`timescale 1ns/1ps

module pzg_pin_board (
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] board_i,
  output logic [7:0] level_o
);
  // A driven line shows the block's level, others the board's changing value
  assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & board_i);
endmodule : pzg_pin_board

// File: verification/testbench.sv
// Testbench for the port 0 block: Wishbone master, pin board and read checks.
// Assumes pzg_pkg and pzg_pin_board are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
  $display("FAIL %s exp %h got %h", nm, ex, gt); num_errors++; end end

module testbench;
  import pzg_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, stop_recover_i, tx_enable_i, tx_data_i, ack_o;
  logic [ADR_W-1:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, exp_v;
  logic [DATA_W-1:0] pin_in_i, pin_out_o, pin_oe_o, board, latch, md, in_m;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  integer seed = 32'hb938;

  pzg_port0 dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .stop_recover_i(stop_recover_i), .tx_enable_i(tx_enable_i), .tx_data_i(tx_data_i),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
  pzg_pin_board board_model (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .board_i(board),
    .level_o(pin_in_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Entered just after a rising edge; returns one idle cycle after the ack edge
  task automatic bus(input logic b, input logic [7:0] idx, input logic w,
                     input logic [7:0] d, input logic [7:0] ex);
    if (!w) begin
      exp_q.push_back(32'(ex));
    end
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {b, idx, 2'b00};
    dat_i <= 32'(d);
    sel_i <= 4'h1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Read answers are matched against the oldest noted expectation
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      // A read answer with no note left can never match the all-ones marker
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffff_ffff;
      `CHK("read data", exp_v, dat_o)
    end
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, stop_recover_i, tx_enable_i, tx_data_i} = 6'h00;
    adr_i = '0;
    sel_i = 4'h0;
    dat_i = '0;
    board = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("oe after reset", 8'h00, pin_oe_o)
    @(posedge clk_i);
    bus(1'b0, IDX_PORT_ZERO_ONE_DIRECTION, 1'b0, 8'h00, 8'h41);
    bus(1'b1, IDX_PORT_ZERO_ONE_DIRECTION, 1'b0, 8'h00, 8'h41);
    bus(1'b0, IDX_PORT_TWO_DIRECTION, 1'b0, 8'h00, 8'hff);
    bus(1'b0, IDX_PORT_THREE_FUNCTION, 1'b0, 8'h00, 8'h00);
    bus(1'b1, IDX_PORT_DRIVER_CONFIG, 1'b0, 8'h00, 8'h0e);
    bus(1'b1, IDX_PORT_FOUR_DIRECTION, 1'b0, 8'h00, 8'hff);
    bus(1'b0, 8'h10, 1'b1, 8'h5a, 8'h00);
    bus(1'b0, 8'h10, 1'b0, 8'h00, 8'h00);
    // Every mix of nibble directions
    for (int i = 0; i < 4; i++) begin
      md = {1'b0, i[1], 5'b00000, i[0]};
      in_m = {{4{md[6]}}, {4{md[0]}}};
      latch = 8'($random(seed));
      board <= 8'($random(seed));
      bus(1'b0, IDX_PORT_ZERO_ONE_DIRECTION, 1'b1, md, 8'h00);
      bus(1'b0, IDX_PORT_ZERO_DATA, 1'b1, latch, 8'h00);
      @(negedge clk_i);
      `CHK("nibble oe", ~in_m, pin_oe_o)
      `CHK("pin out", latch, pin_out_o)
      @(posedge clk_i);
      bus(1'b0, IDX_PORT_ZERO_DATA, 1'b0, 8'h00, (board & in_m) | (latch & ~in_m));
    end
    bus(1'b0, IDX_PORT_ZERO_ONE_DIRECTION, 1'b1, 8'h00, 8'h00);
    bus(1'b1, IDX_PORT_DRIVER_CONFIG, 1'b1, 8'h0a, 8'h00);
    @(negedge clk_i);
    `CHK("open drain oe", ~latch, pin_oe_o)
    `CHK("open drain out", 8'h00, pin_out_o)
    @(posedge clk_i);
    bus(1'b1, IDX_PORT_DRIVER_CONFIG, 1'b1, 8'h0e, 8'h00);
    tx_enable_i <= 1'b1;
    tx_data_i <= ~latch[7];
    @(negedge clk_i);
    `CHK("tx pin", ~latch[7], pin_out_o[7])
    @(posedge clk_i);
    tx_enable_i <= 1'b0;
    stop_recover_i <= 1'b1;
    @(posedge clk_i);
    stop_recover_i <= 1'b0;
    @(negedge clk_i);
    `CHK("oe after stop", 8'h00, pin_oe_o)
    @(posedge clk_i);
    bus(1'b0, IDX_PORT_ZERO_ONE_DIRECTION, 1'b1, 8'h00, 8'h00);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("oe after second reset", 8'h00, pin_oe_o)
    @(posedge clk_i);
    bus(1'b0, IDX_PORT_ZERO_ONE_DIRECTION, 1'b0, 8'h00, 8'h41);
    repeat (3) @(posedge clk_i);
    `CHK("pending reads", 32'd0, 32'(exp_q.size()))
    close_out();
  end
endmodule : testbench
